// ---- hw/eep_top.sv ----
// Function
// RULE_01 - four-byte groups carry check bits; single bit errors fixed on read
// RULE_02 - programming one byte rewrites all four bytes of its group
// RULE_03 - select byte not acknowledged while internal program cycle runs
// RULE_04 - master polls with Start plus select until acknowledged
// RULE_05 - master keeps upper seven select bits equal when polling then reading
// RULE_06 - reads ignore the write protect input
// RULE_07 - address counter advances by one after each byte read
// RULE_08 - no master acknowledge after read byte ends transfer, standby
// RULE_09 - random read: dummy write loads address, repeated Start, read select
// RULE_10 - master ends single random read with no acknowledge and Stop
// RULE_11 - current-address read returns byte at counter then increments
// RULE_12 - one counter shared by array and identification page
// RULE_13 - master should prefer random reads for the main array
// RULE_14 - acknowledged read bytes are followed by the next byte
// RULE_15 - master ends sequential read with no acknowledge and Stop
// RULE_16 - counter wraps past highest address to zero
// RULE_17 - identification page type 1011b, offset from address bits 6 to 0
// RULE_18 - master keeps identification reads inside the 128-byte page
// RULE_19 - identification data byte acknowledged only while page unlocked
// RULE_20 - Start resets decode; truncated command never executes
// RULE_21 - master sends Start then Stop after the lock probe
// RULE_22 - all bytes read as FFh before any programming
// RULE_23 - select bit 0 gives direction, 1 read, 0 write
// RULE_24 - select acknowledged only when chip bits match the straps
// RULE_25 - write select followed by two acknowledged address bytes, high first
// RULE_26 - internal program time is a parameter in clock cycles
`include "eep_defines.svh"

module eep_top
    import eep_pkg::*;
#(
    parameter int PROG_CYCLES = `EEP_PROG_TIME_NS / `EEP_CLK_PERIOD_NS
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [2:0] chip_select_straps,
    input wire logic write_protect_input,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);

    // bit position of data bit j inside the group code word
    function automatic int eep_pos(input int j);
        int p;
        p = 2;
        for (int k = 0; k < 32; k++)
        begin
            if (k <= j)
            begin
                p = p + 1;
                if ((p & (p - 1)) == 0)
                    p = p + 1;
            end
        end
        return p;
    endfunction

    // check bits over one four-byte group
    function automatic logic [5:0] eep_check(input logic [31:0] d);
        logic [5:0] s;
        s = 6'h00;
        for (int j = 0; j < 32; j++)
        begin
            if (d[j])
                s = s ^ 6'(eep_pos(j));
        end
        return s;
    endfunction

    // flip the single data bit that the syndrome points at
    function automatic logic [31:0] eep_fix(input logic [37:0] w);
        logic [31:0] d;
        logic [5:0] syn;
        d = w[31:0];
        syn = eep_check(w[31:0]) ^ w[37:32];
        for (int j = 0; j < 32; j++)
        begin
            if (syn == 6'(eep_pos(j)))
                d[j] = ~d[j];
        end
        return d;
    endfunction

    logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
    logic [2:0] cs_s1_q, cs_s2_q;
    logic wp_s1_q, wp_s2_q;
    logic scl_rise, scl_fall, start_det, stop_det;
    eep_state_t st_q;
    eep_commit_t cm_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q, obuf_q;
    logic id_q, nack_q, sda_oe_q, busy;
    logic [7:0] hi_q;
    logic [15:0] ctr_q;
    logic [8:0] page_q;
    logic pg_id_q, wr_any_q;
    logic [7:0] pbuf [0:127];
    logic [127:0] pval_q;
    logic [37:0] mem [0:`EEP_GROUPS_ALL-1];
    logic [4:0] grp_q;
    logic [31:0] tmr_q;
    logic lock_q;
    logic [31:0] fault_q;
    logic [15:0] ecc_cnt_q;
    logic [14:0] rd_idx, wr_idx;
    logic [37:0] rd_word, wr_old;
    logic [31:0] rd_fixed, wr_new;
    logic [7:0] rd_byte;
    logic load_rd, sel_ok, byte_put;
    logic ahb_wr_q, ahb_rd;
    logic [11:0] ahb_addr_q;
    logic [31:0] hrdata_q;

    // two-stage synchronisers plus one history stage for edges
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
            cs_s1_q <= 3'h0;
            cs_s2_q <= 3'h0;
            wp_s1_q <= 1'b0;
            wp_s2_q <= 1'b0;
        end
        else
        begin
            scl_s1_q <= scl_in;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_in;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
            cs_s1_q <= chip_select_straps;
            cs_s2_q <= cs_s1_q;
            wp_s1_q <= write_protect_input;
            wp_s2_q <= wp_s1_q;
        end
    end

    // line events
    assign scl_rise = scl_s2_q & ~scl_s3_q;
    assign scl_fall = ~scl_s2_q & scl_s3_q;
    assign start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign stop_det = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
    assign busy = (cm_q != EEP_CM_IDLE);

    // select byte check: type, straps, not busy
    assign sel_ok = (sh_q[7:5] == 3'(`EEP_TYPE_ARRAY >> 1)) // [RULE_24]
        && (sh_q[3:1] == cs_s2_q) && !busy; // [RULE_03] [RULE_24]

    // read path: counter picks array or page group, then correction
    assign rd_idx = id_q ? 15'(`EEP_GROUPS_MAIN + {10'h000, ctr_q[6:2]})
        : {1'b0, ctr_q[15:2]}; // [RULE_12] [RULE_17]
    assign rd_word = mem[rd_idx];
    assign rd_fixed = eep_fix(rd_word); // [RULE_01]
    assign rd_byte = rd_fixed[8 * ctr_q[1:0] +: 8];

    // a byte is fetched entering a read or after a master acknowledge
    assign load_rd = scl_fall && (bit_q == 4'h8)
        && ((st_q == EEP_SEL && sel_ok && sh_q[0]) // [RULE_11] [RULE_23]
        || (st_q == EEP_RD && !nack_q)); // [RULE_14]

    // data byte buffered when the write is allowed
    assign byte_put = scl_fall && (bit_q == 4'h7) && st_q == EEP_WR
        && !(id_q ? lock_q : wp_s2_q); // [RULE_19]

    // serial decode machine
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= EEP_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            obuf_q <= 8'hFF;
            id_q <= 1'b0;
            nack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            hi_q <= 8'h00;
            ctr_q <= 16'h0000;
        end
        else if (start_det)
        begin
            // any Start drops the pending decode
            st_q <= EEP_SEL; // [RULE_20]
            bit_q <= 4'hF; // the Start's own clock fall wraps this to 0
            sda_oe_q <= 1'b0;
        end
        else if (stop_det)
        begin
            st_q <= EEP_IDLE; // [RULE_20]
            sda_oe_q <= 1'b0;
        end
        else if (st_q != EEP_IDLE && scl_rise)
        begin
            if (bit_q < 4'h8)
                sh_q <= {sh_q[6:0], sda_s2_q};
            else if (st_q == EEP_RD)
                nack_q <= sda_s2_q; // [RULE_08]
        end
        else if (st_q != EEP_IDLE && scl_fall)
        begin
            if (bit_q == 4'h7)
            begin
                // eighth bit done: choose acknowledge
                bit_q <= 4'h8;
                unique case (st_q)
                    EEP_SEL:
                    begin
                        sda_oe_q <= sel_ok;
                        id_q <= sh_q[4]; // [RULE_17]
                        if (!sel_ok)
                            st_q <= EEP_IDLE; // [RULE_24]
                    end
                    EEP_AHI, EEP_ALO:
                        sda_oe_q <= 1'b1; // [RULE_25]
                    EEP_WR:
                    begin
                        sda_oe_q <= byte_put; // [RULE_19]
                        if (byte_put)
                            ctr_q[6:0] <= ctr_q[6:0] + 7'h01;
                    end
                    EEP_RD:
                        sda_oe_q <= 1'b0;
                    default:
                        sda_oe_q <= 1'b0;
                endcase
                if (st_q == EEP_AHI)
                    hi_q <= sh_q;
                if (st_q == EEP_ALO)
                    ctr_q <= id_q ? {9'h000, sh_q[6:0]} // [RULE_17]
                        : {hi_q, sh_q}; // [RULE_09]
                if (st_q == EEP_WR && !byte_put)
                    st_q <= EEP_IDLE;
            end
            else if (bit_q == 4'h8)
            begin
                // acknowledge slot over: next byte
                bit_q <= 4'h0;
                sda_oe_q <= 1'b0;
                unique case (st_q)
                    EEP_SEL:
                        st_q <= sh_q[0] ? EEP_RD : EEP_AHI; // [RULE_23]
                    EEP_AHI:
                        st_q <= EEP_ALO; // [RULE_25]
                    EEP_ALO, EEP_WR:
                        st_q <= EEP_WR;
                    EEP_RD:
                        if (nack_q)
                            st_q <= EEP_IDLE; // [RULE_08]
                    default:
                        st_q <= EEP_IDLE;
                endcase
                if (load_rd)
                begin
                    // reads never look at write protect
                    obuf_q <= {rd_byte[6:0], 1'b1}; // [RULE_06]
                    sda_oe_q <= ~rd_byte[7];
                    ctr_q <= ctr_q + 16'h0001; // [RULE_07] [RULE_16]
                    nack_q <= 1'b0;
                end
            end
            else
            begin
                bit_q <= bit_q + 4'h1;
                if (st_q == EEP_RD)
                begin
                    sda_oe_q <= ~obuf_q[7];
                    obuf_q <= {obuf_q[6:0], 1'b1};
                end
            end
        end
    end

    // page buffer of written bytes, latched page and target
    always_ff @(posedge ref_clk)
    begin
        if (byte_put)
            pbuf[ctr_q[6:0]] <= sh_q;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pval_q <= 128'h0;
            page_q <= 9'h000;
            pg_id_q <= 1'b0;
            wr_any_q <= 1'b0;
        end
        else if (byte_put)
        begin
            pval_q[ctr_q[6:0]] <= 1'b1;
            page_q <= ctr_q[15:7];
            pg_id_q <= id_q;
            wr_any_q <= 1'b1;
        end
        else if ((start_det && !busy) || (cm_q == EEP_CM_WAIT))
        begin
            // a Start before the Stop discards the bytes
            pval_q <= 128'h0; // [RULE_20]
            wr_any_q <= 1'b0;
        end
    end

    // group read-modify-write: whole group re-encoded and written
    assign wr_idx = pg_id_q ? 15'(`EEP_GROUPS_MAIN + {10'h000, grp_q})
        : {1'b0, page_q, grp_q};
    assign wr_old = mem[wr_idx];
    always_comb
    begin
        wr_new = eep_fix(wr_old);
        for (int b = 0; b < 4; b++)
        begin
            if (pval_q[{grp_q, 2'(b)}])
                wr_new[8 * b +: 8] = pbuf[{grp_q, 2'(b)}];
        end
    end

    // erased content, and group programming
    initial
    begin
        for (int i = 0; i < `EEP_GROUPS_ALL; i++)
            mem[i] = {eep_check(`EEP_ERASED_WORD), `EEP_ERASED_WORD}; // [RULE_22]
    end

    always_ff @(posedge ref_clk)
    begin
        if (cm_q == EEP_CM_GROUP && pval_q[{grp_q, 2'b00} +: 4] != 4'h0)
            mem[wr_idx] <= {eep_check(wr_new), wr_new ^ fault_q}; // [RULE_02]
    end

    // internal program cycle: Stop in the tenth slot after data
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cm_q <= EEP_CM_IDLE;
            grp_q <= 5'h00;
            tmr_q <= 32'h0;
        end
        else
        begin
            unique case (cm_q)
                EEP_CM_IDLE:
                    if (stop_det && st_q == EEP_WR && bit_q == 4'h0 && wr_any_q)
                    begin
                        cm_q <= EEP_CM_GROUP;
                        grp_q <= 5'h00;
                    end
                EEP_CM_GROUP:
                begin
                    grp_q <= grp_q + 5'h01;
                    if (grp_q == 5'h1F)
                    begin
                        cm_q <= EEP_CM_WAIT;
                        tmr_q <= 32'h0;
                    end
                end
                EEP_CM_WAIT:
                begin
                    tmr_q <= tmr_q + 32'h1;
                    if (tmr_q >= 32'(PROG_CYCLES - 1))
                        cm_q <= EEP_CM_IDLE; // [RULE_26]
                end
                default:
                    cm_q <= EEP_CM_IDLE;
            endcase
        end
    end

    // corrected reads counter
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            ecc_cnt_q <= `EEP_ECCCNT_RESET;
        else if (load_rd && eep_check(rd_word[31:0]) != rd_word[37:32])
            ecc_cnt_q <= ecc_cnt_q + 16'h0001; // [RULE_01]
    end

    // bus address phase capture
    assign ahb_rd = hsel && htrans[1] && hready && !hwrite;
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ahb_wr_q <= 1'b0;
            ahb_addr_q <= 12'h000;
        end
        else if (hready)
        begin
            ahb_wr_q <= hsel && htrans[1] && hwrite;
            ahb_addr_q <= haddr[11:0];
        end
    end

    // writable registers: lock is sticky until reset
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lock_q <= 1'b0;
            fault_q <= `EEP_FAULT_RESET;
        end
        else if (ahb_wr_q)
        begin
            if (ahb_addr_q == `EEP_REG_CTRL && hwdata[`EEP_CTRL_LOCK_BIT])
                lock_q <= 1'b1;
            if (ahb_addr_q == `EEP_REG_FAULT)
                fault_q <= hwdata;
        end
    end

    // read data registered in the address phase
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            hrdata_q <= 32'h0;
        else if (ahb_rd)
        begin
            unique case (haddr[11:0])
                `EEP_REG_CTRL:
                    hrdata_q <= {31'h0, lock_q};
                `EEP_REG_FAULT:
                    hrdata_q <= fault_q;
                `EEP_REG_STATUS:
                    hrdata_q <= {ctr_q, 14'h0, lock_q, busy};
                `EEP_REG_ECCCNT:
                    hrdata_q <= {16'h0, ecc_cnt_q};
                default:
                    hrdata_q <= 32'h0;
            endcase
        end
    end

    // outputs
    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_q;

endmodule

// ---- hw/eep_defines.svh ----
`ifndef EEP_DEFINES_SVH
`define EEP_DEFINES_SVH

// clock and internal program time
`define EEP_CLK_PERIOD_NS 50
`define EEP_PROG_TIME_NS 5000000

// select byte type codes (upper nibble)
`define EEP_TYPE_ARRAY 4'hA
`define EEP_TYPE_IDPAGE 4'hB

// memory organisation
`define EEP_GROUPS_MAIN 16384
`define EEP_GROUPS_ID 32
`define EEP_GROUPS_ALL 16416
`define EEP_ERASED_WORD 32'hFFFFFFFF

// register offsets (byte addresses)
`define EEP_REG_CTRL 12'h000
`define EEP_REG_FAULT 12'h004
`define EEP_REG_STATUS 12'h008
`define EEP_REG_ECCCNT 12'h00C

// field positions and reset values
`define EEP_CTRL_LOCK_BIT 0
`define EEP_STAT_BUSY_BIT 0
`define EEP_STAT_LOCK_BIT 1
`define EEP_STAT_CTR_LSB 16
`define EEP_FAULT_RESET 32'h00000000
`define EEP_ECCCNT_RESET 16'h0000

`endif

// ---- hw/eep_pkg.sv ----
package eep_pkg;

    // serial decode states
    typedef enum logic [2:0] {
        EEP_IDLE = 3'b000,
        EEP_SEL = 3'b001,
        EEP_AHI = 3'b010,
        EEP_ALO = 3'b011,
        EEP_WR = 3'b100,
        EEP_RD = 3'b101
    } eep_state_t;

    // internal program cycle states
    typedef enum logic [1:0] {
        EEP_CM_IDLE = 2'b00,
        EEP_CM_GROUP = 2'b01,
        EEP_CM_WAIT = 2'b10
    } eep_commit_t;

endpackage

// ---- bench/eep_checker_assertions.sv ----
module eep_checker (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_oe,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    logic rd_req;
    // read address phase taken this edge
    assign rd_req = hsel && htrans[1] && hready && !hwrite;
    ready_high_a: assert property (hreadyout)
        else $error("wait state inserted");
    resp_okay_a: assert property (!hresp)
        else $error("response not okay");
    reset_quiet_a: assert property ($rose(reset_n) |-> !sda_oe && !hrdata)
        else $error("outputs busy after reset");
    idle_release_a: assert property (scl_in [*8] |-> !sda_oe)
        else $error("data line held on idle bus");
    stop_release_a: assert property (scl_in && $past(scl_in) &&
        $rose(sda_in) |-> !sda_oe [*8])
        else $error("data line driven after stop");
    start_quiet_a: assert property (scl_in && $past(scl_in) &&
        $fell(sda_in) && !$past(sda_oe) |=> !sda_oe [*4])
        else $error("data line driven after start");
    unmapped_zero_a: assert property (rd_req && haddr[11:0] == 12'h010
        |=> hrdata == 32'h0)
        else $error("unmapped offset returned data");
    rdata_hold_a: assert property (!rd_req |=> $stable(hrdata))
        else $error("read data changed without a read");
endmodule

bind eep_top eep_checker u_chk (.ref_clk, .reset_n, .scl_in, .sda_in,
    .sda_oe, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp);

// ---- bench/eep_tw_master.sv ----
module eep_tw_master (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int QTR = 100;
    // bus idle: clock high, data released
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // one bit: data set mid-low, sampled mid-high
    task automatic bit_slot(input logic b, output logic s);
        #QTR sda_pull <= !b;
        #QTR scl <= 1'b1;
        #QTR s = sda;
        #QTR scl <= 1'b0;
    endtask
    // start or repeated start, odd offset keeps phase apart from ref_clk
    task automatic start();
        #13 sda_pull <= 1'b0;
        #(2*QTR) scl <= 1'b1;
        #(2*QTR) sda_pull <= 1'b1;
        #(2*QTR) scl <= 1'b0;
    endtask
    // stop leaves the clock standing high
    task automatic stop();
        #QTR sda_pull <= 1'b1;
        #QTR scl <= 1'b1;
        #(2*QTR) sda_pull <= 1'b0;
        #(2*QTR);
    endtask
    // byte out, msb first, ninth slot released for the ack
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(d[i], s);
        bit_slot(1'b1, s);
        ack = !s;
    endtask
    // byte in; the last byte is left unacknowledged
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_slot(1'b1, s);
            d[i] = s;
        end
        bit_slot(!more, s);
    endtask
endmodule

// ---- bench/testbench.sv ----
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] straps = 3'h0;
    logic wp = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, sda_out, sda_oe, scl, m_pull;
    wire sda = !m_pull && (!sda_oe || sda_out);
    int fails = 0;
    int checks_done = 0;
    int seed = 34;
    logic [7:0] mem [int];
    eep_top #(.PROG_CYCLES(200)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_straps(straps), .write_protect_input(wp),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    eep_tw_master u_m (.scl(scl), .sda_pull(m_pull), .sda(sda));
    // 20 MHz reference clock
    initial
    begin
        forever #25 ref_clk = !ref_clk;
    end
    task automatic conclude();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            fails++;
            conclude();
        end
    endtask
    // single word transfer, data taken at the end of the data phase
    task automatic ahb(input logic wr, input logic [11:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    // model key: id page bytes live above the array
    function automatic int key(logic [3:0] ty, int v);
        return (ty == 4'hB) ? 32'h10000 + (v & 127) : v & 32'hFFFF;
    endfunction
    function automatic logic [7:0] exp_at(logic [3:0] ty, int v);
        return mem.exists(key(ty, v)) ? mem[key(ty, v)] : 8'hFF;
    endfunction
    task automatic sel(input logic [3:0] ty, input logic rw, input logic e);
        logic ack;
        u_m.start();
        u_m.wbyte({ty, straps, rw}, ack);
        `CHK("select ack", e, ack)
    endtask
    task automatic set_addr(input logic [3:0] ty, input logic [15:0] a);
        logic ack;
        sel(ty, 1'b0, 1'b1);
        u_m.wbyte(a[15:8], ack);
        `CHK("addr hi ack", 1'b1, ack)
        u_m.wbyte(a[7:0], ack);
        `CHK("addr lo ack", 1'b1, ack)
    endtask
    // n bytes from a; cur skips the dummy write and a is the counter
    task automatic rd(input logic [3:0] ty, input logic [15:0] a, input int n,
        input logic cur);
        logic [7:0] d;
        if (!cur)
            set_addr(ty, a);
        sel(ty, 1'b1, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            u_m.rbyte(i < n - 1, d);
            `CHK("read byte", exp_at(ty, a + i), d)
        end
        u_m.stop();
    endtask
    // program n random bytes, then poll until the select is taken
    task automatic wr(input logic [3:0] ty, input logic [15:0] a, input int n);
        logic ack;
        logic [7:0] v;
        int naks;
        set_addr(ty, a);
        for (int i = 0; i < n; i++)
        begin
            v = 8'($random(seed));
            u_m.wbyte(v, ack);
            `CHK("data ack", 1'b1, ack)
            mem[key(ty, a + i)] = v;
        end
        u_m.stop();
        naks = 0;
        do
        begin
            u_m.start();
            u_m.wbyte({ty, straps, 1'b0}, ack);
            naks += !ack;
        end
        while (!ack && naks < 30);
        u_m.stop();
        `CHK("busy refusals", 1'b1, naks > 0)
        `CHK("poll taken", 1'b1, ack)
    endtask
    // main sequence
    initial
    begin
        logic [31:0] r;
        logic ack;
        logic [15:0] g;
        straps = 3'($random(seed));
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        ahb(1'b0, 12'h008, 32'h0, r);
        `CHK("status after reset", 32'h0, r)
        ahb(1'b0, 12'h010, 32'h0, r);
        `CHK("unmapped read", 32'h0, r)
        g = 16'($random(seed));
        wp <= 1'b1;
        rd(4'hA, g, 2, 1'b0);
        u_m.start();
        u_m.wbyte({4'hA, ~straps, 1'b1}, ack);
        u_m.stop();
        `CHK("foreign select", 1'b0, ack)
        @(posedge ref_clk);
        wp <= 1'b0;
        wr(4'hA, 16'h0000, 2);
        rd(4'hA, 16'hFFFF, 3, 1'b0);
        ahb(1'b0, 12'h008, 32'h0, r);
        `CHK("counter after wrap", 16'h0002, r[31:16])
        rd(4'hA, 16'h0000, 1, 1'b0);
        rd(4'hA, 16'h0001, 1, 1'b1);
        g = 16'($random(seed)) & 16'hFFFC;
        ahb(1'b1, 12'h004, 32'h0000_0004, r); // flip a bit of untouched byte 0
        wr(4'hA, g + 16'h1, 1);
        ahb(1'b1, 12'h004, 32'h0, r);
        rd(4'hA, g, 4, 1'b0);
        ahb(1'b0, 12'h00C, 32'h0, r);
        `CHK("corrections seen", 16'h0004, r[15:0])
        wr(4'hB, 16'hFF85, 2);
        rd(4'hB, 16'h3A84, 3, 1'b0);
        ahb(1'b0, 12'h008, 32'h0, r);
        `CHK("counter in id page", 16'h0007, r[31:16])
        rd(4'hB, 16'h0000, 1, 1'b0);
        rd(4'hA, 16'h0001, 1, 1'b1);
        for (int k = 0; k < 2; k++)
        begin
            set_addr(4'hB, 16'h0010);
            u_m.wbyte(8'h5A, ack);
            `CHK("lock probe", k == 0, ack)
            u_m.start();
            u_m.stop();
            ahb(1'b0, 12'h008, 32'h0, r);
            `CHK("probe dropped", 2'(k << 1), r[1:0])
            ahb(1'b1, 12'h000, 32'h1, r);
        end
        rd(4'hB, 16'h0010, 1, 1'b0);
        repeat (6)
        begin
            g = 16'($random(seed));
            rd(4'hA, g, 1 + ({$random(seed)} % 3), 1'b0);
        end
        conclude();
    end
endmodule
